// ---- logic/ueb_pkg.sv ----
package ueb_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_HOLD      = 4'h0;
  localparam logic [3:0] ADDR_MASK      = 4'h1;
  localparam logic [3:0] ADDR_SRC       = 4'h2;
  localparam logic [3:0] ADDR_LINE      = 4'h3;
  localparam logic [3:0] ADDR_MODEM     = 4'h4;
  localparam logic [3:0] ADDR_LSTAT     = 4'h5;
  localparam logic [3:0] ADDR_MSTAT     = 4'h6;
  localparam logic [3:0] ADDR_SEVEN     = 4'h7;
  localparam logic [3:0] ADDR_GPIO_DIR  = 4'hA;
  localparam logic [3:0] ADDR_GPIO_LVL  = 4'hB;
  localparam logic [3:0] ADDR_GPIO_MASK = 4'hC;
  localparam logic [3:0] ADDR_RESERVED  = 4'hD;
  localparam logic [3:0] ADDR_IO_SETUP  = 4'hE;
  localparam logic [3:0] ADDR_EXTRA     = 4'hF;

  // ----------------------------------------------------------------
  // access keys and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] LINE_KEY_ENH   = 8'hBF;
  localparam int         LINE_DIV_BIT   = 7;
  localparam int         ENH_UNLOCK_BIT = 4;
  localparam int         QUEUE_EN_BIT   = 0;
  localparam int         IO_RESET_BIT   = 3;

  // enhanced mask, queue and modem bits only take writes while the unlock bit is set; io setup and extra bits always do
  localparam logic [7:0] MASK_ENH_BITS  = 8'hF0;
  localparam logic [7:0] QUEUE_ENH_BITS = 8'h30;
  localparam logic [7:0] MODEM_ENH_BITS = 8'hE0;
  localparam logic [7:0] IO_SETUP_BITS  = 8'h07;
  localparam logic [7:0] EXTRA_BITS     = 8'h86;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] RST_LINE       = 8'h00;

  // ----------------------------------------------------------------
  // interrupt source codes, status bits 5:0
  // ----------------------------------------------------------------
  localparam logic [5:0] SRC_LINE_ERR   = 6'h06;
  localparam logic [5:0] SRC_RX_READY   = 6'h04;
  localparam logic [5:0] SRC_TX_READY   = 6'h02;
  localparam logic [5:0] SRC_MODEM      = 6'h00;
  localparam logic [5:0] SRC_PAUSE_CHAR = 6'h10;
  localparam logic [5:0] SRC_FLOW_PIN   = 6'h20;
  localparam logic [5:0] SRC_NONE       = 6'h01;

endpackage

// ---- logic/ueb_irq_gate.sv ----
`timescale 1ns/1ps

module ueb_irq_gate
  import ueb_pkg::*;
(
  input  wire logic [7:0] irqMask,
  input  wire logic       enhanced,
  input  wire logic       fifoEnabled,
  input  wire logic       rxDataReady,
  input  wire logic       rxFifoTrigger,
  input  wire logic       txReady,
  input  wire logic       lineError,
  input  wire logic       modemChange,
  input  wire logic       pauseCharSeen,
  input  wire logic       flowPinRise,
  output logic      [5:0] sourceCode,
  output logic            pending
);

  // ----------------------------------------------------------------
  // source gating
  // ----------------------------------------------------------------
  wire logic rxSource  = fifoEnabled ? rxFifoTrigger : rxDataReady;
  wire logic rxGated   = irqMask[0] & rxSource;
  wire logic txGated   = irqMask[1] & txReady;
  wire logic lineGated = irqMask[2] & lineError;
  wire logic modGated  = irqMask[3] & modemChange;
  wire logic xoffGated = enhanced & irqMask[5] & pauseCharSeen;
  wire logic flowGated = enhanced & (irqMask[6] | irqMask[7]) & flowPinRise;

  // ----------------------------------------------------------------
  // source code, highest level first
  // ----------------------------------------------------------------
  assign sourceCode = lineGated ? SRC_LINE_ERR   :
                      rxGated   ? SRC_RX_READY   :
                      txGated   ? SRC_TX_READY   :
                      modGated  ? SRC_MODEM      :
                      xoffGated ? SRC_PAUSE_CHAR :
                      flowGated ? SRC_FLOW_PIN   :
                                  SRC_NONE;
  assign pending = lineGated | rxGated | txGated | modGated | xoffGated | flowGated;

endmodule // ueb_irq_gate

// ---- logic/ueb_register_bank.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Enhanced bits accept writes and act only while the unlock bit of the enhanced register is set.
// - The unlock bit opens mask bits 7:4, status bits 5:4, queue bits 5:4, modem bits 7:5, fraction.
// - Receive, transmit, line and modem interrupt sources pass only where their mask bit is set.
// - The highest-priority source passing the mask is reported in the interrupt status register for the host.
// - The receive holding register is read-only and host writes never disturb received data.
// - The transmit holding register is write-only; writes queue a character, reads give rx data.
// - Flow-control characters and the enhanced register are reachable only with line control at BF.
// - With mask bit 0 the rx interrupt follows a held character, or the trigger level in FIFO mode.

module ueb_register_bank
  import ueb_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [3:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic [7:0] rxChar,
  input  wire logic       rxDataReady,
  input  wire logic       rxFifoTrigger,
  input  wire logic       txReady,
  input  wire logic       lineError,
  input  wire logic       modemChange,
  input  wire logic       pauseCharSeen,
  input  wire logic       flowPinRise,
  input  wire logic [7:0] lineStatusIn,
  input  wire logic [7:0] modemStatusIn,
  input  wire logic [7:0] gpioIn,
  output logic            rxPop,
  output logic      [7:0] txChar,
  output logic            txPush,
  output logic            queueWrite,
  output logic      [7:0] queueCtrl,
  output logic      [7:0] lineCtrl,
  output logic      [7:0] modemCtrl,
  output logic      [7:0] irqMaskEff,
  output logic      [5:0] irqSource,
  output logic            irqPending,
  output logic     [15:0] baudDivisor,
  output logic      [7:0] baudFraction,
  output logic      [7:0] enhancedCtrl,
  output logic     [31:0] flowChars,
  output logic      [7:0] gpioDir,
  output logic      [7:0] gpioOut,
  output logic      [7:0] gpioIrqMask,
  output logic      [2:0] ioSetup,
  output logic            uartSoftReset,
  output logic      [7:0] extraCtrl
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] lineReg,  lineNext;
  logic [7:0] maskReg,  maskNext;
  logic [7:0] queueReg, queueNext;
  logic [7:0] modemReg, modemNext;
  logic [7:0] dllReg,   dllNext;
  logic [7:0] dlmReg,   dlmNext;
  logic [7:0] fracReg,  fracNext;
  logic [7:0] enhReg,   enhNext;
  logic [7:0] xon1Reg,  xon1Next;
  logic [7:0] xon2Reg,  xon2Next;
  logic [7:0] xoff1Reg, xoff1Next;
  logic [7:0] xoff2Reg, xoff2Next;
  logic [7:0] dirReg,   dirNext;
  logic [7:0] lvlReg,   lvlNext;
  logic [7:0] gmaskReg, gmaskNext;
  logic [2:0] ioReg,    ioNext;
  logic [7:0] extraReg, extraNext;
  logic [7:0] txReg;
  logic       txPushReg;
  logic       queueWriteReg;
  logic       swResetReg;
  logic [7:0] rdataReg;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic bankEnh  = (lineReg == LINE_KEY_ENH);
  wire logic bankDiv  = lineReg[LINE_DIV_BIT] & ~bankEnh;
  wire logic bankStd  = ~bankEnh & ~bankDiv;
  wire logic unlocked = enhReg[ENH_UNLOCK_BIT];

  wire logic hitHold  = (regAddr == ADDR_HOLD);
  wire logic hitMask  = (regAddr == ADDR_MASK);
  wire logic hitSrc   = (regAddr == ADDR_SRC);
  wire logic hitModem = (regAddr == ADDR_MODEM);
  wire logic hitLstat = (regAddr == ADDR_LSTAT);
  wire logic hitMstat = (regAddr == ADDR_MSTAT);
  wire logic hitSeven = (regAddr == ADDR_SEVEN);

  wire logic wrLine   = regWrite & (regAddr == ADDR_LINE);
  wire logic wrDll    = regWrite & hitHold  & bankDiv;
  wire logic wrDlm    = regWrite & hitMask  & bankDiv;
  wire logic wrFrac   = regWrite & hitSrc   & bankDiv & unlocked;
  wire logic wrEnh    = regWrite & hitSrc   & bankEnh;
  wire logic wrTx     = regWrite & hitHold  & ~bankDiv;
  wire logic wrMask   = regWrite & hitMask  & ~bankDiv;
  wire logic wrQueue  = regWrite & hitSrc   & bankStd;
  wire logic wrModem  = regWrite & hitModem & ~bankEnh;
  wire logic wrXon1   = regWrite & hitModem & bankEnh;
  wire logic wrXon2   = regWrite & hitLstat & bankEnh;
  wire logic wrXoff1  = regWrite & hitMstat & bankEnh;
  wire logic wrXoff2  = regWrite & hitSeven & bankEnh;
  wire logic wrDir    = regWrite & (regAddr == ADDR_GPIO_DIR);
  wire logic wrLvl    = regWrite & (regAddr == ADDR_GPIO_LVL);
  wire logic wrGmask  = regWrite & (regAddr == ADDR_GPIO_MASK);
  wire logic wrIo     = regWrite & (regAddr == ADDR_IO_SETUP);
  wire logic wrExtra  = regWrite & (regAddr == ADDR_EXTRA);

  // ----------------------------------------------------------------
  // write data, locked enhanced bits keep their old value
  // ----------------------------------------------------------------
  wire logic [7:0] maskKeep  = unlocked ? 8'h00 : MASK_ENH_BITS;
  wire logic [7:0] queueKeep = unlocked ? 8'h00 : QUEUE_ENH_BITS;
  wire logic [7:0] modemKeep = unlocked ? 8'h00 : MODEM_ENH_BITS;

  assign lineNext  = wrLine  ? regWdata : lineReg;
  assign maskNext  = wrMask  ? ((regWdata & ~maskKeep) | (maskReg & maskKeep)) : maskReg;
  assign queueNext = wrQueue ? ((regWdata & ~queueKeep) | (queueReg & queueKeep)) : queueReg;
  assign modemNext = wrModem ? ((regWdata & ~modemKeep) | (modemReg & modemKeep)) : modemReg;
  assign dllNext   = wrDll   ? regWdata : dllReg;
  assign dlmNext   = wrDlm   ? regWdata : dlmReg;
  assign fracNext  = wrFrac  ? regWdata : fracReg;
  assign enhNext   = wrEnh   ? regWdata : enhReg;
  assign xon1Next  = wrXon1  ? regWdata : xon1Reg;
  assign xon2Next  = wrXon2  ? regWdata : xon2Reg;
  assign xoff1Next = wrXoff1 ? regWdata : xoff1Reg;
  assign xoff2Next = wrXoff2 ? regWdata : xoff2Reg;
  assign dirNext   = wrDir   ? regWdata : dirReg;
  assign lvlNext   = wrLvl   ? regWdata : lvlReg;
  assign gmaskNext = wrGmask ? regWdata : gmaskReg;
  assign ioNext    = wrIo    ? regWdata[2:0] : ioReg;
  assign extraNext = wrExtra ? (regWdata & EXTRA_BITS) : extraReg;

  // ----------------------------------------------------------------
  // interrupt gating
  // ----------------------------------------------------------------
  logic [5:0] srcCode;
  logic       srcPending;

  ueb_irq_gate u_irq_gate (
    .irqMask       (maskReg),
    .enhanced      (unlocked),
    .fifoEnabled   (queueReg[QUEUE_EN_BIT]),
    .rxDataReady   (rxDataReady),
    .rxFifoTrigger (rxFifoTrigger),
    .txReady       (txReady),
    .lineError     (lineError),
    .modemChange   (modemChange),
    .pauseCharSeen (pauseCharSeen),
    .flowPinRise   (flowPinRise),
    .sourceCode    (srcCode),
    .pending       (srcPending)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] gpioRead;
  genvar      gi;

  generate
    for (gi = 0; gi < 8; gi++) begin : g_gpio_read
      // outputs read back what was written, inputs read the pin
      assign gpioRead[gi] = dirReg[gi] ? lvlReg[gi] : gpioIn[gi];
    end
  endgenerate

  wire logic [7:0] isrRead   = {{2{queueReg[QUEUE_EN_BIT]}},
                                (unlocked ? srcCode[5:4] : 2'b00), srcCode[3:0]};
  wire logic [7:0] holdRead  = bankDiv ? dllReg : rxChar;
  wire logic [7:0] maskRead  = bankDiv ? dlmReg : maskReg;
  wire logic [7:0] srcRead   = bankEnh ? enhReg :
                               bankDiv ? (unlocked ? fracReg : 8'h00) : isrRead;
  wire logic [7:0] modemRead = bankEnh ? xon1Reg  : modemReg;
  wire logic [7:0] lstatRead = bankEnh ? xon2Reg  : lineStatusIn;
  wire logic [7:0] mstatRead = bankEnh ? xoff1Reg : modemStatusIn;
  wire logic [7:0] sevenRead = bankEnh ? xoff2Reg : 8'h00;

  logic [7:0] readMux;
  always_comb begin
    unique case (regAddr)
      ADDR_HOLD:      readMux = holdRead;
      ADDR_MASK:      readMux = maskRead;
      ADDR_SRC:       readMux = srcRead;
      ADDR_LINE:      readMux = lineReg;
      ADDR_MODEM:     readMux = modemRead;
      ADDR_LSTAT:     readMux = lstatRead;
      ADDR_MSTAT:     readMux = mstatRead;
      ADDR_SEVEN:     readMux = sevenRead;
      ADDR_GPIO_DIR:  readMux = dirReg;
      ADDR_GPIO_LVL:  readMux = gpioRead;
      ADDR_GPIO_MASK: readMux = gmaskReg;
      ADDR_RESERVED:  readMux = 8'h00;
      ADDR_IO_SETUP:  readMux = {5'h00, ioReg};
      ADDR_EXTRA:     readMux = extraReg;
      default:        readMux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lineReg  <= RST_LINE;
      maskReg  <= RST_BYTE;
      queueReg <= RST_BYTE;
      modemReg <= RST_BYTE;
      enhReg   <= RST_BYTE;
    end else begin
      lineReg  <= lineNext;
      maskReg  <= maskNext;
      queueReg <= queueNext;
      modemReg <= modemNext;
      enhReg   <= enhNext;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dllReg   <= RST_BYTE;
      dlmReg   <= RST_BYTE;
      fracReg  <= RST_BYTE;
      xon1Reg  <= RST_BYTE;
      xon2Reg  <= RST_BYTE;
      xoff1Reg <= RST_BYTE;
      xoff2Reg <= RST_BYTE;
    end else begin
      dllReg   <= dllNext;
      dlmReg   <= dlmNext;
      fracReg  <= fracNext;
      xon1Reg  <= xon1Next;
      xon2Reg  <= xon2Next;
      xoff1Reg <= xoff1Next;
      xoff2Reg <= xoff2Next;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dirReg   <= RST_BYTE;
      lvlReg   <= RST_BYTE;
      gmaskReg <= RST_BYTE;
      ioReg    <= 3'b000;
      extraReg <= RST_BYTE;
    end else begin
      dirReg   <= dirNext;
      lvlReg   <= lvlNext;
      gmaskReg <= gmaskNext;
      ioReg    <= ioNext;
      extraReg <= extraNext;
    end
  end

  // transmit queueing, queue control strobe, soft reset and read data
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      txReg         <= RST_BYTE;
      txPushReg     <= 1'b0;
      queueWriteReg <= 1'b0;
      swResetReg    <= 1'b0;
      rdataReg      <= RST_BYTE;
    end else begin
      txReg         <= wrTx ? regWdata : txReg;
      txPushReg     <= wrTx;
      queueWriteReg <= wrQueue;
      swResetReg    <= wrIo & regWdata[IO_RESET_BIT];
      rdataReg      <= regRead ? readMux : rdataReg;
    end
  end

  // ----------------------------------------------------------------
  // outputs, enhanced bits act only while unlocked
  // ----------------------------------------------------------------
  assign regRdata      = rdataReg;
  assign rxPop         = regRead & hitHold & ~bankDiv;
  assign txChar        = txReg;
  assign txPush        = txPushReg;
  assign queueWrite    = queueWriteReg;
  assign queueCtrl     = queueReg & ~queueKeep;
  assign lineCtrl      = lineReg;
  assign modemCtrl     = modemReg & ~modemKeep;
  assign irqMaskEff    = maskReg & ~maskKeep;
  assign irqSource     = isrRead[5:0];
  assign irqPending    = srcPending;
  assign baudDivisor   = {dlmReg, dllReg};
  assign baudFraction  = unlocked ? fracReg : 8'h00;
  assign enhancedCtrl  = enhReg;
  assign flowChars     = {xoff2Reg, xoff1Reg, xon2Reg, xon1Reg};
  assign gpioDir       = dirReg;
  assign gpioOut       = lvlReg;
  assign gpioIrqMask   = gmaskReg;
  assign ioSetup       = ioReg;
  assign uartSoftReset = swResetReg;
  assign extraCtrl     = extraReg;

endmodule // ueb_register_bank

// ---- dv/ueb_assertions.sv ----
`timescale 1ns/1ps

module ueb_checker
  import ueb_pkg::*;
(
  input logic        ref_clk,
  input logic        reset,
  input logic [3:0]  regAddr,
  input logic        regWrite,
  input logic        regRead,
  input logic [7:0]  regWdata,
  input logic [7:0]  regRdata,
  input logic        rxDataReady,
  input logic        rxFifoTrigger,
  input logic        lineError,
  input logic        rxPop,
  input logic [7:0]  txChar,
  input logic        txPush,
  input logic [7:0]  queueCtrl,
  input logic [7:0]  lineCtrl,
  input logic [7:0]  modemCtrl,
  input logic [7:0]  irqMaskEff,
  input logic [5:0]  irqSource,
  input logic        irqPending,
  input logic [15:0] baudDivisor,
  input logic [7:0]  baudFraction,
  input logic [7:0]  enhancedCtrl,
  input logic [31:0] flowChars
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  wire divBank = lineCtrl[LINE_DIV_BIT] && (lineCtrl != LINE_KEY_ENH);
  wire wrAt0   = regWrite && (regAddr == ADDR_HOLD);

  a_rx_pop:
    assert property (rxPop == (regRead && regAddr == ADDR_HOLD && !divBank))
    else $error("rx pop mismatch");
  a_tx_push:
    assert property (wrAt0 && !divBank |=> txPush && txChar == $past(regWdata))
    else $error("tx push missing");
  a_lock_bits:
    assert property (!enhancedCtrl[ENH_UNLOCK_BIT] && $past(!enhancedCtrl[ENH_UNLOCK_BIT])
      |-> irqMaskEff[7:4] == 4'h0 && modemCtrl[7:5] == 3'h0 && queueCtrl[5:4] == 2'h0
          && baudFraction == 8'h00)
    else $error("locked bits active");
  a_flow_lock:
    assert property (regWrite && regAddr >= ADDR_MODEM && regAddr <= ADDR_SEVEN
      && lineCtrl != LINE_KEY_ENH |=> $stable(flowChars))
    else $error("flow char written without key");
  a_flow_key:
    assert property (regWrite && regAddr == ADDR_MODEM && lineCtrl == LINE_KEY_ENH
      |=> flowChars[7:0] == $past(regWdata))
    else $error("flow char write lost");
  a_div_low:
    assert property (wrAt0 && divBank |=> baudDivisor[7:0] == $past(regWdata) && !txPush)
    else $error("divisor low write wrong");
  a_line_first:
    assert property (lineError && irqMaskEff[2] |-> irqPending && irqSource == SRC_LINE_ERR)
    else $error("line error not reported");
  a_none_masked:
    assert property (irqMaskEff == 8'h00 |-> !irqPending && irqSource == SRC_NONE)
    else $error("masked source raised");
  a_rx_source:
    assert property (irqMaskEff[0] && !irqMaskEff[2]
      && (queueCtrl[QUEUE_EN_BIT] ? rxFifoTrigger : rxDataReady) |-> irqSource == SRC_RX_READY)
    else $error("rx source not reported");
  a_src_read:
    assert property (regRead && regAddr == ADDR_SRC && !lineCtrl[LINE_DIV_BIT]
      |=> regRdata[3:0] == $past(irqSource[3:0]))
    else $error("status read wrong");

  c_tx_push: cover property (wrAt0 && !divBank);
  c_div_write: cover property (wrAt0 && divBank);
  c_line_err: cover property (lineError && irqMaskEff[2]);
endmodule // ueb_checker

bind ueb_register_bank ueb_checker chk (
  .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
  .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
  .rxDataReady(rxDataReady), .rxFifoTrigger(rxFifoTrigger), .lineError(lineError),
  .rxPop(rxPop), .txChar(txChar), .txPush(txPush), .queueCtrl(queueCtrl),
  .lineCtrl(lineCtrl), .modemCtrl(modemCtrl), .irqMaskEff(irqMaskEff),
  .irqSource(irqSource), .irqPending(irqPending), .baudDivisor(baudDivisor),
  .baudFraction(baudFraction), .enhancedCtrl(enhancedCtrl), .flowChars(flowChars)
);

// ---- dv/ueb_host_model.sv ----
`timescale 1ns/1ps

module ueb_host_model (
  input  logic       ref_clk,
  output logic [3:0] regAddr,
  output logic       regWrite,
  output logic       regRead,
  output logic [7:0] regWdata,
  input  logic [7:0] regRdata,
  input  logic       rxPop
);
  initial begin
    regAddr = 4'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 8'h00;
  end

  // strobe is taken at the second edge; released data is inverted so it cannot linger
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    regWdata <= ~d;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic pop);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    #1;
    pop = rxPop;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask
endmodule // ueb_host_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin \
  nChecks++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); \
  end \
end

module tb;
  import ueb_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  regAddr;
  logic        regWrite, regRead, rxPop, txPush, irqPending;
  logic [7:0]  regWdata, regRdata, txChar, queueCtrl, lineCtrl, modemCtrl;
  logic [7:0]  irqMaskEff, baudFraction;
  logic [7:0]  rxChar = 8'hA5;
  logic        rxDataReady = 1'b0, rxFifoTrigger = 1'b0, txReady = 1'b0;
  logic        lineError = 1'b0, modemChange = 1'b0;
  logic        pauseCharSeen = 1'b0, flowPinRise = 1'b0;
  logic        queueWrite, uartSoftReset;
  logic [7:0]  gpioDir, gpioOut, gpioIrqMask, extraCtrl, enhancedCtrl;
  logic [2:0]  ioSetup;
  logic [5:0]  irqSource;
  logic [15:0] baudDivisor;
  logic [31:0] flowChars;
  int          errors = 0, nChecks = 0, cycles = 0;
  logic [7:0]  d;
  logic        p;

  always #5 ref_clk = ~ref_clk;

  ueb_host_model host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .rxPop(rxPop));

  ueb_register_bank DUT (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .rxChar(rxChar), .rxDataReady(rxDataReady), .rxFifoTrigger(rxFifoTrigger),
    .txReady(txReady), .lineError(lineError), .modemChange(modemChange),
    .pauseCharSeen(pauseCharSeen), .flowPinRise(flowPinRise), .lineStatusIn(8'h5A),
    .modemStatusIn(8'h00), .gpioIn(8'h3C), .rxPop(rxPop), .txChar(txChar),
    .txPush(txPush), .queueWrite(queueWrite), .queueCtrl(queueCtrl), .lineCtrl(lineCtrl),
    .modemCtrl(modemCtrl), .irqMaskEff(irqMaskEff), .irqSource(irqSource),
    .irqPending(irqPending), .baudDivisor(baudDivisor), .baudFraction(baudFraction),
    .enhancedCtrl(enhancedCtrl), .flowChars(flowChars), .gpioDir(gpioDir),
    .gpioOut(gpioOut), .gpioIrqMask(gpioIrqMask), .ioSetup(ioSetup),
    .uartSoftReset(uartSoftReset), .extraCtrl(extraCtrl));

  task automatic t_regs();
    logic [7:0] exp [6] = '{8'h00, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      host.rd(ADDR_GPIO_DIR + 4'(i), d, p);
      `CHK(d, exp[i]) // reset value
    end
    host.wr(ADDR_RESERVED, 8'hFF);
    host.wr(ADDR_EXTRA, 8'hFF);
    `CHK(extraCtrl, EXTRA_BITS) // writable bits only
    host.rd(ADDR_RESERVED, d, p);
    `CHK(d, 8'h00) // reserved
    host.rd(ADDR_EXTRA, d, p);
    `CHK(d, EXTRA_BITS) // writable bits only
    host.wr(ADDR_GPIO_DIR, 8'h0F);
    host.wr(ADDR_GPIO_LVL, 8'h05);
    host.wr(ADDR_GPIO_MASK, 8'hA5);
    `CHK({gpioDir, gpioOut, gpioIrqMask}, 24'h0F05A5) // gpio registers
    host.rd(ADDR_GPIO_LVL, d, p);
    `CHK(d, 8'h35) // outputs read level, inputs read pins
    host.wr(ADDR_IO_SETUP, 8'h0F);
    `CHK({uartSoftReset, ioSetup}, 4'hF) // soft reset pulse
    @(posedge ref_clk);
    #1;
    `CHK(uartSoftReset, 1'b0) // one cycle pulse
    $display("regs done");
  endtask

  task automatic t_hold();
    host.wr(ADDR_HOLD, 8'h41);
    `CHK(txPush, 1'b1)
    `CHK(txChar, 8'h41)
    @(posedge ref_clk);
    #1;
    `CHK(txPush, 1'b0)
    host.rd(ADDR_HOLD, d, p);
    `CHK(d, 8'hA5)
    `CHK(p, 1'b1)
    host.rd(ADDR_LSTAT, d, p);
    `CHK({p, d}, 9'h05A) // line status byte, no pop
    $display("hold done");
  endtask

  task automatic t_lock();
    host.wr(ADDR_MASK, 8'hFF);
    `CHK(irqMaskEff, 8'h0F)
    host.wr(ADDR_MODEM, 8'hFF);
    `CHK(modemCtrl, 8'h1F)
    host.wr(ADDR_SRC, 8'h31);
    `CHK(queueCtrl, 8'h01)
    `CHK(queueWrite, 1'b1) // queue control strobe
    host.wr(ADDR_LINE, LINE_KEY_ENH);
    `CHK(lineCtrl, LINE_KEY_ENH)
    host.wr(ADDR_SRC, 8'h10);
    `CHK(enhancedCtrl, 8'h10)
    `CHK(queueWrite, 1'b0)
    host.wr(ADDR_LINE, 8'h00);
    `CHK(irqMaskEff, 8'h0F)
    host.wr(ADDR_MASK, 8'hFF);
    `CHK(irqMaskEff, 8'hFF)
    host.wr(ADDR_MODEM, 8'hFF);
    `CHK(modemCtrl, 8'hFF)
    $display("lock done");
  endtask

  task automatic t_irq();
    logic [5:0] code [4] = '{SRC_RX_READY, SRC_TX_READY, SRC_LINE_ERR, SRC_MODEM};
    for (int i = 0; i < 4; i++) begin
      host.wr(ADDR_MASK, 8'h01 << i);
      @(posedge ref_clk);
      {modemChange, lineError, txReady, rxFifoTrigger} <= 4'hF;
      #1;
      `CHK(irqSource, code[i])
      host.rd(ADDR_SRC, d, p);
      `CHK(d, {2'b11, code[i]})
      @(posedge ref_clk);
      {modemChange, lineError, txReady, rxFifoTrigger} <= 4'h0;
    end
    host.wr(ADDR_MASK, 8'hE0);
    @(posedge ref_clk);
    {flowPinRise, pauseCharSeen} <= 2'b11;
    #1;
    `CHK(irqSource, SRC_PAUSE_CHAR)
    host.wr(ADDR_MASK, 8'hC0);
    `CHK(irqSource, SRC_FLOW_PIN)
    @(posedge ref_clk);
    {flowPinRise, pauseCharSeen} <= 2'b00;
    host.wr(ADDR_MASK, 8'h01);
    @(posedge ref_clk);
    rxDataReady <= 1'b1;
    #1;
    `CHK(irqSource, SRC_NONE)
    host.wr(ADDR_SRC, 8'h00);
    `CHK(irqSource, SRC_RX_READY)
    host.wr(ADDR_MASK, 8'h00);
    `CHK(irqPending, 1'b0)
    @(posedge ref_clk);
    rxDataReady <= 1'b0;
    $display("irq done");
  endtask

  task automatic t_banks();
    host.wr(ADDR_LINE, 8'h80);
    host.wr(ADDR_HOLD, 8'h12);
    `CHK(txPush, 1'b0)
    host.wr(ADDR_MASK, 8'h34);
    `CHK(baudDivisor, 16'h3412)
    `CHK(irqMaskEff, 8'h00)
    host.wr(ADDR_SRC, 8'h05);
    `CHK(baudFraction, 8'h05)
    host.rd(ADDR_HOLD, d, p);
    `CHK({p, d}, 9'h012)
    host.wr(ADDR_MODEM, 8'h77);
    `CHK(flowChars, 32'h0)
    host.wr(ADDR_LINE, LINE_KEY_ENH);
    for (int i = 0; i < 4; i++) host.wr(ADDR_MODEM + 4'(i), 8'hC0 + 8'(i));
    `CHK(flowChars, 32'hC3C2C1C0)
    host.rd(ADDR_HOLD, d, p);
    `CHK(d, 8'hA5)
    host.wr(ADDR_LINE, 8'h00);
    $display("banks done");
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_hold();
    t_lock();
    t_irq();
    t_banks();
    summarize();
  end
endmodule // tb
